// >>> tvsf_defines.vh
`ifndef TVSF_DEFINES_VH
`define TVSF_DEFINES_VH

// ==================================================================
// Timing
// ==================================================================
`define TVSF_CLK_PERIOD_NS     10
// Control cycle of the drive, one filter pass per period
`define TVSF_SAMPLE_PERIOD_NS  62500
`define TVSF_SAMPLE_CYCLES     (`TVSF_SAMPLE_PERIOD_NS / `TVSF_CLK_PERIOD_NS)
// Time constant step of 0.01 ms
`define TVSF_TAU_UNIT_NS       10000

// ==================================================================
// Coefficient scaling, Q16 except the 2^24 frequency constant
// ==================================================================
`define TVSF_Q                 16
// 2*pi*Ts*2^24, tied to the sample period above
`define TVSF_FREQ_K            16'h19BA
`define TVSF_F_MAX             18'h0E000
`define TVSF_D_MAX             18'h20000
// Roughly 65536/100, turns depth in percent into a gain
`define TVSF_DEPTH_SCALE       16'h028F
`define TVSF_DEPTH_FULL        7'h64

// ==================================================================
// Automatic third notch and low-frequency stages
// ==================================================================
`define TVSF_AUTO_FREQ_BASE    16'h00C8
`define TVSF_AUTO_FREQ_STEP    16'h0032
`define TVSF_AUTO_WIDTH_SHIFT  2
`define TVSF_AUTO_DEPTH        7'h0A
`define TVSF_LF_WIDTH_SHIFT    1
`define TVSF_STAGES            5
`define TVSF_JOBS              6

`endif

// >>> tvsf_fifo.v
`timescale 1ns/100ps

module tvsf_fifo #(
    parameter W     = 16,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire          sys_clk,
    input  wire          reset,
    input  wire [W-1:0]  in_data,
    input  wire          in_valid,
    output wire          in_ready,
    output reg  [W-1:0]  out_data,
    output reg           out_valid,
    input  wire          out_ready
);

    reg [W-1:0]  mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0]   count;

    wire push = in_valid && in_ready;
    wire pop  = (count != {(AW+1){1'b0}}) && (!out_valid || out_ready);

    assign in_ready = (count != DEPTH[AW:0]);

    always @(posedge sys_clk) begin
        if (reset) begin
            wr_ptr    <= {AW{1'b0}};
            rd_ptr    <= {AW{1'b0}};
            count     <= {(AW+1){1'b0}};
            out_data  <= {W{1'b0}};
            out_valid <= 1'b0;
        end else begin
            if (push) begin
                mem[wr_ptr] <= in_data;
                wr_ptr      <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            end
            if (pop) begin
                out_data <= mem[rd_ptr];
                rd_ptr   <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
            end
            if (pop)
                out_valid <= 1'b1;
            else if (out_ready)
                out_valid <= 1'b0;
            if (push && !pop)
                count <= count + 1'b1;
            else if (pop && !push)
                count <= count - 1'b1;
        end
    end

endmodule // tvsf_fifo

// >>> tvsf_filters.v
// Function
// - First-order low-pass on torque, cutoff 1/(2*pi*tau), tau in 0.01 ms steps
// - Each notch cuts around its center frequency; width is the 3 dB span
// - Depth is output/input ratio at center; zero cancels fully
// - Three independent notch groups, each with own frequency, width, depth
// - Auto notch control set to 1 enables self-adjusting notch tuning
// - Stiffness rise with auto and drive enabled retunes third notch group
// - Auto notch control at 0 stops automatic third notch adjustment
// - Low-frequency end-vibration stage tuned by its own frequency setting
// - Second independent low-frequency stage with its own frequency setting
`timescale 1ns/100ps
`include "tvsf_defines.vh"

module tvsf_filters #(
    parameter DW         = 16,
    parameter SAMPLE_DIV = `TVSF_SAMPLE_CYCLES,
    parameter FIFO_DEPTH = 16,
    parameter FIFO_AW    = 4
) (
    input  wire          sys_clk,
    input  wire          reset,
    input  wire [DW-1:0] torque_in,
    input  wire          torque_in_valid,
    output reg           torque_in_ready,
    output wire [DW-1:0] torque_out,
    output wire          torque_out_valid,
    input  wire          torque_out_ready,
    input  wire          drive_enable,
    input  wire          auto_notch_control,
    input  wire [4:0]    stiffness_level,
    input  wire [15:0]   torque_filter_time_constant,
    input  wire [15:0]   notch1_frequency,
    input  wire [15:0]   notch1_width,
    input  wire [6:0]    notch1_depth,
    input  wire [15:0]   notch2_frequency,
    input  wire [15:0]   notch2_width,
    input  wire [6:0]    notch2_depth,
    input  wire [15:0]   notch3_frequency,
    input  wire [15:0]   notch3_width,
    input  wire [6:0]    notch3_depth,
    input  wire [15:0]   low_freq_suppress_freq_a,
    input  wire [15:0]   low_freq_suppress_freq_b,
    output reg  [15:0]   auto_notch3_frequency,
    output reg  [15:0]   auto_notch3_width,
    output reg  [6:0]    auto_notch3_depth
);

    localparam ST_IDLE  = 2'h0;
    localparam ST_LPF   = 2'h1;
    localparam ST_STAGE = 2'h2;
    localparam ST_PUSH  = 2'h3;

    // ==================================================================
    // Fixed-point helpers
    // ==================================================================
    function signed [31:0] mulq;
        input [17:0]        c;
        input signed [31:0] v;
        reg signed [50:0]   p;
        begin
            p    = $signed({1'b0, c}) * v;
            mulq = p[47:16];
        end
    endfunction

    function [DW-1:0] sat;
        input signed [31:0] v;
        begin
            if (v > $signed({{(33-DW){1'b0}}, {(DW-1){1'b1}}}))
                sat = {1'b0, {(DW-1){1'b1}}};
            else if (v < $signed({{(33-DW){1'b1}}, {(DW-1){1'b0}}}))
                sat = {1'b1, {(DW-1){1'b0}}};
            else
                sat = v[DW-1:0];
        end
    endfunction

    // ==================================================================
    // Control-cycle tick
    // ==================================================================
    reg [15:0] div_cnt;
    reg        tick_pending;
    wire       accept = torque_in_ready && torque_in_valid;

    always @(posedge sys_clk) begin
        if (reset) begin
            div_cnt      <= 16'h0000;
            tick_pending <= 1'b0;
        end else begin
            div_cnt <= (div_cnt == SAMPLE_DIV[15:0] - 16'h0001) ? 16'h0000 : div_cnt + 16'h0001;
            if (div_cnt == 16'h0000)
                tick_pending <= 1'b1;
            else if (accept)
                tick_pending <= 1'b0;
        end
    end

    // ==================================================================
    // Automatic third notch
    // ==================================================================
    reg  [4:0]  stiff_prev;
    wire [15:0] auto_freq = `TVSF_AUTO_FREQ_BASE
                          + `TVSF_AUTO_FREQ_STEP * {11'h000, stiffness_level};

    always @(posedge sys_clk) begin
        if (reset) begin
            stiff_prev            <= 5'h00;
            auto_notch3_frequency <= `TVSF_AUTO_FREQ_BASE;
            auto_notch3_width     <= `TVSF_AUTO_FREQ_BASE >> `TVSF_AUTO_WIDTH_SHIFT;
            auto_notch3_depth     <= `TVSF_AUTO_DEPTH;
        end else begin
            stiff_prev <= stiffness_level;
            if (auto_notch_control && drive_enable && stiffness_level > stiff_prev) begin
                auto_notch3_frequency <= auto_freq;
                auto_notch3_width     <= auto_freq >> `TVSF_AUTO_WIDTH_SHIFT;
                auto_notch3_depth     <= `TVSF_AUTO_DEPTH;
            end
        end
    end

    // ==================================================================
    // Stage settings: notch 1..3, then low-frequency a and b
    // ==================================================================
    reg [15:0] s_freq  [0:`TVSF_STAGES-1];
    reg [15:0] s_width [0:`TVSF_STAGES-1];
    reg [6:0]  s_depth [0:`TVSF_STAGES-1];

    always @* begin
        s_freq[0]  = notch1_frequency;
        s_width[0] = notch1_width;
        s_depth[0] = notch1_depth;
        s_freq[1]  = notch2_frequency;
        s_width[1] = notch2_width;
        s_depth[1] = notch2_depth;
        // manual values when auto is off
        s_freq[2]  = auto_notch_control ? auto_notch3_frequency : notch3_frequency;
        s_width[2] = auto_notch_control ? auto_notch3_width : notch3_width;
        s_depth[2] = auto_notch_control ? auto_notch3_depth : notch3_depth;
        s_freq[3]  = low_freq_suppress_freq_a;
        s_width[3] = low_freq_suppress_freq_a >> `TVSF_LF_WIDTH_SHIFT;
        s_depth[3] = 7'h00;
        s_freq[4]  = low_freq_suppress_freq_b;
        s_width[4] = low_freq_suppress_freq_b >> `TVSF_LF_WIDTH_SHIFT;
        s_depth[4] = 7'h00;
    end

    // ==================================================================
    // Serial divider, round robin over damping and low-pass gain
    // ==================================================================
    reg  [2:0]  job;
    reg  [5:0]  bit_cnt;
    reg         div_busy;
    reg  [31:0] quo;
    reg  [31:0] den;
    reg  [32:0] rem;
    reg  [17:0] coef_sh [0:`TVSF_JOBS-1];
    integer     m;
    reg  [31:0] job_num;
    reg  [31:0] job_den;
    wire [32:0] trial = {rem[31:0], quo[31]} - {1'b0, den};

    always @* begin
        if (job == 3'h5) begin
            // alpha = Ts / (tau + Ts)
            job_num = `TVSF_SAMPLE_PERIOD_NS << `TVSF_Q;
            job_den = torque_filter_time_constant * `TVSF_TAU_UNIT_NS + `TVSF_SAMPLE_PERIOD_NS;
        end else begin
            // damping = width / center, sets the 3 dB span
            job_num = {s_width[job], 16'h0000};
            job_den = {16'h0000, s_freq[job]};
        end
    end

    always @(posedge sys_clk) begin
        if (reset) begin
            job      <= 3'h0;
            bit_cnt  <= 6'h00;
            div_busy <= 1'b0;
            quo      <= 32'h00000000;
            den      <= 32'h00000000;
            rem      <= 33'h000000000;
            // Zero gains first, so no unknown reaches the low-pass state
            for (m = 0; m < `TVSF_JOBS; m = m + 1)
                coef_sh[m] <= 18'h00000;
        end else if (!div_busy) begin
            quo      <= job_num;
            den      <= job_den;
            rem      <= 33'h000000000;
            bit_cnt  <= 6'h20;
            div_busy <= 1'b1;
        end else if (bit_cnt != 6'h00) begin
            bit_cnt <= bit_cnt - 6'h01;
            if (!trial[32]) begin
                rem <= trial;
                quo <= {quo[30:0], 1'b1};
            end else begin
                rem <= {rem[31:0], quo[31]};
                quo <= {quo[30:0], 1'b0};
            end
        end else begin
            // Zero denominator gives all ones; the stage is bypassed then
            coef_sh[job] <= (quo > {14'h0000, `TVSF_D_MAX}) ? `TVSF_D_MAX : quo[17:0];
            job          <= (job == 3'h5) ? 3'h0 : job + 3'h1;
            div_busy     <= 1'b0;
        end
    end

    // ==================================================================
    // Committed coefficients, swapped only between samples
    // ==================================================================
    reg [17:0] f_c [0:`TVSF_STAGES-1];
    reg [17:0] d_c [0:`TVSF_STAGES-1];
    reg [17:0] g_c [0:`TVSF_STAGES-1];
    reg [17:0] alpha_c;
    reg [31:0] fprod [0:`TVSF_STAGES-1];
    reg [6:0]  dclip [0:`TVSF_STAGES-1];
    reg [22:0] gprod [0:`TVSF_STAGES-1];
    integer    i;
    integer    j;
    integer    k;

    always @* begin
        for (i = 0; i < `TVSF_STAGES; i = i + 1) begin
            fprod[i] = s_freq[i] * `TVSF_FREQ_K;
            dclip[i] = (s_depth[i] > `TVSF_DEPTH_FULL) ? `TVSF_DEPTH_FULL : s_depth[i];
            gprod[i] = (`TVSF_DEPTH_FULL - dclip[i]) * `TVSF_DEPTH_SCALE;
        end
    end

    always @(posedge sys_clk) begin
        if (reset) begin
            alpha_c <= 18'h00000;
            for (j = 0; j < `TVSF_STAGES; j = j + 1) begin
                f_c[j] <= 18'h00000;
                d_c[j] <= 18'h00000;
                g_c[j] <= 18'h00000;
            end
        end else if (accept) begin
            alpha_c <= coef_sh[5];
            for (j = 0; j < `TVSF_STAGES; j = j + 1) begin
                f_c[j] <= (s_freq[j] == 16'h0000) ? 18'h00000 :
                          (fprod[j][31:8] > {6'h00, `TVSF_F_MAX}) ? `TVSF_F_MAX : fprod[j][25:8];
                d_c[j] <= coef_sh[j];
                // gain on the band part is 1 - depth/100
                g_c[j] <= {2'b00, gprod[j][15:0]};
            end
        end
    end

    // ==================================================================
    // Sample pipeline
    // ==================================================================
    reg        [1:0]  state;
    reg        [2:0]  stg;
    reg signed [31:0] sig;
    reg signed [31:0] lpf_y;
    reg signed [31:0] lp [0:`TVSF_STAGES-1];
    reg signed [31:0] bp [0:`TVSF_STAGES-1];
    reg signed [31:0] lp_n;
    reg signed [31:0] hp;
    reg signed [31:0] bp_n;
    reg signed [31:0] y_n;
    reg        [DW-1:0] fifo_data;
    reg               fifo_valid;
    wire              fifo_ready;

    // state-variable notch: y = x - g * (d * band)
    always @* begin
        lp_n = lp[stg] + mulq(f_c[stg], bp[stg]);
        hp   = sig - lp_n - mulq(d_c[stg], bp[stg]);
        bp_n = bp[stg] + mulq(f_c[stg], hp);
        // Old band value keeps the notch zero on the tuned frequency
        y_n  = sig - mulq(g_c[stg], mulq(d_c[stg], bp[stg]));
    end

    always @(posedge sys_clk) begin
        if (reset) begin
            state           <= ST_IDLE;
            stg             <= 3'h0;
            sig             <= 32'sh00000000;
            lpf_y           <= 32'sh00000000;
            torque_in_ready <= 1'b0;
            fifo_data       <= {DW{1'b0}};
            fifo_valid      <= 1'b0;
            for (k = 0; k < `TVSF_STAGES; k = k + 1) begin
                lp[k] <= 32'sh00000000;
                bp[k] <= 32'sh00000000;
            end
        end else begin
            fifo_valid      <= 1'b0;
            torque_in_ready <= (state == ST_IDLE) && tick_pending && fifo_ready
                               && !fifo_valid && !accept;
            case (state)
                ST_IDLE: begin
                    if (accept) begin
                        sig   <= {{(32-DW){torque_in[DW-1]}}, torque_in};
                        state <= ST_LPF;
                    end
                end
                ST_LPF: begin
                    // y += alpha * (x - y)
                    lpf_y <= lpf_y + mulq(alpha_c, sig - lpf_y);
                    sig   <= lpf_y + mulq(alpha_c, sig - lpf_y);
                    stg   <= 3'h0;
                    state <= ST_STAGE;
                end
                ST_STAGE: begin
                    // stages in series; unused ones pass and clear
                    if (f_c[stg] == 18'h00000) begin
                        lp[stg] <= 32'sh00000000;
                        bp[stg] <= 32'sh00000000;
                    end else begin
                        lp[stg] <= lp_n;
                        bp[stg] <= bp_n;
                        sig     <= y_n;
                    end
                    if (stg == 3'h4)
                        state <= ST_PUSH;
                    else
                        stg <= stg + 3'h1;
                end
                ST_PUSH: begin
                    // Room was checked at accept and only pops happen since
                    fifo_data  <= sat(sig);
                    fifo_valid <= 1'b1;
                    state      <= ST_IDLE;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ==================================================================
    // Output buffer toward the current loop
    // ==================================================================
    tvsf_fifo #(
        .W     (DW),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .reset     (reset),
        .in_data   (fifo_data),
        .in_valid  (fifo_valid),
        .in_ready  (fifo_ready),
        .out_data  (torque_out),
        .out_valid (torque_out_valid),
        .out_ready (torque_out_ready)
    );

endmodule // tvsf_filters

// >>> tvsf_filters_asserts.sv
`timescale 1ns/100ps

// ==================================================================
// Port checker for the filter chain
// ==================================================================
module tvsf_filters_asserts (
    input wire        sys_clk,
    input wire        reset,
    input wire        torque_in_valid,
    input wire        torque_in_ready,
    input wire [15:0] torque_out,
    input wire        torque_out_valid,
    input wire        torque_out_ready,
    input wire        drive_enable,
    input wire        auto_notch_control,
    input wire [4:0]  stiffness_level,
    input wire [15:0] auto_notch3_frequency,
    input wire [15:0] auto_notch3_width,
    input wire [6:0]  auto_notch3_depth
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    // Stiffness rises while automatic tuning may act
    sequence s_raise;
        auto_notch_control && drive_enable && (stiffness_level > $past(stiffness_level));
    endsequence
    sequence s_accept;
        torque_in_valid && torque_in_ready;
    endsequence

    property p_reset_idle;
        $fell(reset) |-> !torque_in_ready && !torque_out_valid && torque_out == 16'h0000;
    endproperty
    property p_reset_auto;
        $fell(reset) |-> auto_notch3_frequency == 16'h00C8 && auto_notch3_width == 16'h0032
            && auto_notch3_depth == 7'h0A;
    endproperty
    property p_auto_freq;
        s_raise |=> auto_notch3_frequency == 16'h00C8 + 16'h0032 * $past(stiffness_level);
    endproperty
    property p_auto_width;
        s_raise |=> auto_notch3_width == (auto_notch3_frequency >> 2);
    endproperty
    property p_auto_depth;
        s_raise |=> auto_notch3_depth == 7'h0A;
    endproperty
    property p_manual_hold;
        !auto_notch_control |=> $stable(auto_notch3_frequency) && $stable(auto_notch3_width)
            && $stable(auto_notch3_depth);
    endproperty
    property p_drive_hold;
        !drive_enable |=> $stable(auto_notch3_frequency);
    endproperty
    property p_no_rise_hold;
        stiffness_level <= $past(stiffness_level) |=> $stable(auto_notch3_frequency);
    endproperty
    property p_ready_hold;
        torque_in_ready && !torque_in_valid |=> torque_in_ready;
    endproperty
    property p_ready_drop;
        s_accept |=> !torque_in_ready;
    endproperty
    property p_out_hold;
        torque_out_valid && !torque_out_ready |=> torque_out_valid && $stable(torque_out);
    endproperty

    a_reset_idle: assert property (p_reset_idle) else $error("outputs not idle after reset");
    a_reset_auto: assert property (p_reset_auto) else $error("auto values not reset");
    a_auto_freq: assert property (p_auto_freq) else $error("auto frequency wrong");
    a_auto_width: assert property (p_auto_width) else $error("auto width wrong");
    a_auto_depth: assert property (p_auto_depth) else $error("auto depth wrong");
    a_manual_hold: assert property (p_manual_hold) else $error("auto values moved");
    a_drive_hold: assert property (p_drive_hold) else $error("tuned while disabled");
    a_no_rise_hold: assert property (p_no_rise_hold) else $error("tuned without rise");
    a_ready_hold: assert property (p_ready_hold) else $error("ready withdrawn");
    a_ready_drop: assert property (p_ready_drop) else $error("ready after accept");
    a_out_hold: assert property (p_out_hold) else $error("output not held");
endmodule // tvsf_filters_asserts

bind tvsf_filters tvsf_filters_asserts u_tvsf_filters_asserts (
    .sys_clk(sys_clk), .reset(reset), .torque_in_valid(torque_in_valid),
    .torque_in_ready(torque_in_ready), .torque_out(torque_out),
    .torque_out_valid(torque_out_valid), .torque_out_ready(torque_out_ready),
    .drive_enable(drive_enable), .auto_notch_control(auto_notch_control),
    .stiffness_level(stiffness_level), .auto_notch3_frequency(auto_notch3_frequency),
    .auto_notch3_width(auto_notch3_width), .auto_notch3_depth(auto_notch3_depth));

// >>> tvsf_sink_model.sv
`timescale 1ns/100ps

// ==================================================================
// Current loop side: takes filtered torque words
// ==================================================================
module tvsf_sink_model (
    input  wire        sys_clk,
    input  wire        reset,
    input  wire [15:0] torque_out,
    input  wire        torque_out_valid,
    input  wire [1:0]  mode,
    output logic       torque_out_ready
);
    logic [15:0] rx_q[$];
    logic        phase = 1'b0;

    // Mode 0 prompt, 1 stalled, 2 every other cycle
    always @(negedge sys_clk) begin : drv
        logic nr;
        nr = !reset && (mode == 2'h0 || (mode == 2'h2 && phase));
        // Word is taken at the coming rising edge
        if (nr && torque_out_valid === 1'b1) rx_q.push_back(torque_out);
        torque_out_ready <= nr;
        phase <= ~phase;
    end
endmodule // tvsf_sink_model

// >>> tvsf_filters_tb.sv
`timescale 1ns/100ps

module tvsf_filters_tb;
    localparam int SD = 32;
    logic        sys_clk = 1'b0;
    logic        reset = 1'b1;
    logic [15:0] torque_in = 16'h0000;
    logic        torque_in_valid = 1'b0;
    logic        drive_enable = 1'b0;
    logic        auto_notch_control = 1'b0;
    logic [4:0]  stiffness_level = 5'h00;
    logic [15:0] tau, f1, w1, f2, w2, f3, w3, lfa, lfb;
    logic [6:0]  d1, d2, d3;
    logic [1:0]  mode = 2'h0;
    wire         torque_in_ready, torque_out_valid, torque_out_ready;
    wire  [15:0] torque_out, a_freq, a_width;
    wire  [6:0]  a_depth;
    int          error_cnt = 0;
    int          n_checks = 0;
    logic [15:0] sine [16] = '{16'h0000, 16'h0BF5, 16'h1619, 16'h1CDF,
                               16'h1F40, 16'h1CDF, 16'h1619, 16'h0BF5,
                               16'h0000, 16'hF40B, 16'hE9E7, 16'hE321,
                               16'hE0C0, 16'hE321, 16'hE9E7, 16'hF40B};
    logic [6:0]  tbl [4] = '{7'h2A, 7'h4C, 7'h68, 7'h6E};

    always #5 sys_clk = ~sys_clk;

    tvsf_filters #(.SAMPLE_DIV(SD)) u_tvsf_filters (
        .sys_clk(sys_clk), .reset(reset), .torque_in(torque_in),
        .torque_in_valid(torque_in_valid), .torque_in_ready(torque_in_ready),
        .torque_out(torque_out), .torque_out_valid(torque_out_valid),
        .torque_out_ready(torque_out_ready), .drive_enable(drive_enable),
        .auto_notch_control(auto_notch_control), .stiffness_level(stiffness_level),
        .torque_filter_time_constant(tau), .notch1_frequency(f1), .notch1_width(w1),
        .notch1_depth(d1), .notch2_frequency(f2), .notch2_width(w2), .notch2_depth(d2),
        .notch3_frequency(f3), .notch3_width(w3), .notch3_depth(d3),
        .low_freq_suppress_freq_a(lfa), .low_freq_suppress_freq_b(lfb),
        .auto_notch3_frequency(a_freq), .auto_notch3_width(a_width),
        .auto_notch3_depth(a_depth));

    tvsf_sink_model u_tvsf_sink_model (
        .sys_clk(sys_clk), .reset(reset), .torque_out(torque_out),
        .torque_out_valid(torque_out_valid), .mode(mode),
        .torque_out_ready(torque_out_ready));

    // ==================================================================
    // Access tasks
    // ==================================================================
    task automatic chk(input bit ok, input string msg);
        n_checks++;
        if (!ok) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask

    task automatic clear();
        {tau, f1, w1, f2, w2, f3, w3, lfa, lfb} = '0;
        {d1, d2, d3} = '0;
    endtask

    // Valid held until ready seen high; lim cycles then withdrawn
    task automatic send(input logic [15:0] v, input int lim, output bit ok);
        int i;
        @(negedge sys_clk);
        ok = 1'b0;
        torque_in = v;
        torque_in_valid = 1'b1;
        for (i = 0; i < lim && !ok; i++) begin
            if (torque_in_ready === 1'b1) ok = 1'b1;
            @(negedge sys_clk);
        end
        torque_in_valid = 1'b0;
    endtask

    task automatic get(output logic [15:0] o);
        int i;
        o = 'x;
        for (i = 0; i < 4 * SD && u_tvsf_sink_model.rx_q.size() == 0; i++) @(negedge sys_clk);
        if (u_tvsf_sink_model.rx_q.size() > 0) o = u_tvsf_sink_model.rx_q.pop_front();
        chk(^o !== 1'bx, "no output word");
    endtask

    task automatic xfer(input logic [15:0] v, output logic [15:0] o);
        bit ok;
        send(v, 4 * SD, ok);
        chk(ok, "sample not taken");
        get(o);
    endtask

    // Tone of sixteen samples a period against one stage set to that frequency
    task automatic tone(input int k, input logic [6:0] d, input bit cut);
        logic [15:0] o;
        int i, v, pk;
        clear();
        case (k)
            0: begin f1 = 16'h03E8; w1 = 16'h01F4; d1 = d; end
            1: begin f2 = 16'h03E8; w2 = 16'h01F4; d2 = d; end
            2: begin f3 = 16'h03E8; w3 = 16'h01F4; d3 = d; end
            3: lfa = 16'h03E8;
            default: lfb = 16'h03E8;
        endcase
        pk = 0;
        for (i = 0; i < 80; i++) begin
            xfer(sine[i % 16], o);
            v = $signed(o);
            if (v < 0) v = -v;
            if (i >= 64 && v > pk) pk = v;
        end
        chk(cut ? (pk < 1000) : (pk > 6000), "tone response");
        $display("test tone %0d depth %0d done", k, d);
    endtask

    task conclude;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ==================================================================
    // Tests
    // ==================================================================
    initial begin : main
        logic [15:0] o, e;
        bit ok;
        int i, n;
        clear();
        repeat (5) @(negedge sys_clk);
        reset = 1'b0;
        chk(a_freq === 16'h00C8 && a_width === 16'h0032 && a_depth === 7'h0A, "auto reset");
        // Coefficients are zero straight after reset
        repeat (8) xfer(16'h0000, o);
        for (i = 0; i < 8; i++) begin
            e = 16'(i * 16'h2493) + 16'h7FFF;
            xfer(e, o);
            chk(o === e, "passthrough word");
        end
        $display("test passthrough done");
        mode = 2'h1;
        ok = 1'b1;
        for (n = 0; n < 20 && ok; n += int'(ok)) send(16'(n * 16'h0123), 3 * SD, ok);
        chk(!ok && n >= 16, "buffer never refused");
        mode = 2'h2;
        for (i = 0; i < n; i++) begin
            get(o);
            chk(o === 16'(i * 16'h0123), "buffer order");
        end
        mode = 2'h0;
        $display("test buffer done");
        tau = 16'h0064;
        repeat (8) xfer(16'h0000, o);
        xfer(16'h1F40, o);
        chk($signed(o) > 0 && $signed(o) < 2000, "low-pass first step");
        repeat (40) xfer(16'h1F40, o);
        chk($signed(o) > 6000 && $signed(o) <= 8000, "low-pass settle");
        $display("test low-pass done");
        for (i = 0; i < 5; i++) tone(i, 7'h00, 1'b1);
        tone(0, 7'h64, 1'b0);
        @(negedge sys_clk);
        {auto_notch_control, drive_enable} = 2'b11;
        for (i = 1; i < 5; i++) begin
            stiffness_level = 5'(i);
            repeat (2) @(negedge sys_clk);
            e = 16'h00C8 + 16'(i) * 16'h0032;
            chk(a_freq === e && a_width === (e >> 2) && a_depth === 7'h0A, "auto tune");
        end
        for (i = 0; i < 4; i++) begin
            {auto_notch_control, drive_enable, stiffness_level} = tbl[i];
            repeat (2) @(negedge sys_clk);
            if (i == 3) e = 16'h0384;
            chk(a_freq === e, "auto gating");
        end
        $display("test auto notch done");
        conclude();
    end

    initial begin : watchdog
        #700000;
        error_cnt++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        conclude();
    end
endmodule // tvsf_filters_tb
